/* src/bpg_map.svh */
`ifndef BPG_MAP_SVH
`define BPG_MAP_SVH

// Screen organisation in cells
`define BPG_CELL_ROWS      25
`define BPG_CELL_COLS      40
`define BPG_CELL_BYTES     8
`define BPG_ROW_BYTES      320
`define BPG_BITMAP_BYTES   8000

// Control bit positions of the host mode registers
`define BPG_CTRL1_BITMAP_BIT 5
`define BPG_CTRL2_MULTI_BIT  4

// Multi-colour pair codes
`define BPG_PAIR_BG0       2'h0
`define BPG_PAIR_SCR_HI    2'h1
`define BPG_PAIR_SCR_LO    2'h2
`define BPG_PAIR_COLMEM    2'h3

// Reset values
`define BPG_RESET_COLOR    4'h0
`define BPG_RESET_BYTE     8'h00

`endif

/* src/bpg_pkg.sv */
package bpg_pkg;

  // Display mode taken from the control bits
  typedef enum logic [1:0] {
    bpg_mode_char,
    bpg_mode_two_color_bitmap,
    bpg_mode_multi_color_bitmap
  } bpg_mode_type;

  // Whole state of the pixel generator
  typedef struct packed {
    logic         s1_valid;
    logic         s1_new_cell;
    logic [2:0]   s1_x_lo;
    bpg_mode_type s1_mode;
    logic         fetch;
    logic [12:0]  bm_addr;
    logic [9:0]   scr_addr;
    logic [7:0]   hold_bm;
    logic [7:0]   hold_scr;
    logic [3:0]   hold_col;
    logic         out_valid;
    logic         out_bitmap;
    logic [3:0]   out_color;
  } bpg_state_type;

endpackage

/* src/bpg_pixel_gen.sv */
`timescale 1ns/10ps
`include "bpg_map.svh"
// Overview of operation
// - In standard bitmap mode the screen byte gives the colours of its 8x8 cell, and colour memory is ignored.
// - In standard bitmap mode a one bit shows the screen byte high nibble colour and a zero bit the low nibble.
// - Coordinate zero, zero is the upper-left pixel, x grows rightward and y grows downward.
// - The bitmap is 25 rows of 40 cells, each cell eight consecutive bytes, one per pixel line.
// - The cell row is y divided by eight and each cell row sits 320 bytes further from the base.
// - The cell in a row is x divided by eight and each cell sits 8 bytes further on.
// - The low three bits of y are added as the byte offset of the pixel line in the cell.
// - Bit 7 of a bitmap byte is the leftmost pixel, so the bit used is seven minus the low three bits of x.
// - An 8K bitmap area maps one to one onto the screen in both bitmap modes.
// - Multi-colour bitmap mode holds only while the first control bit 5 and second control bit 4 are both one.
// - Multi-colour mode forms each double-width dot from two adjacent bits, 160 dots of four colours.
// - Multi-colour colours come from background 0, screen high nibble, screen low nibble and colour memory.
// - Standard bitmap mode holds while the first control bit 5 is one and the second control bit 4 is zero, character modes when bit 5 is zero.
module bpg_pixel_gen
  import bpg_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       reset,
  input  wire logic       pix_valid,
  input  wire logic [8:0] pix_x,
  input  wire logic [7:0] pix_y,
  input  wire logic [7:0] ctrl1,
  input  wire logic [7:0] ctrl2,
  input  wire logic [3:0] bg0_color,
  output logic            mem_fetch,
  output logic [12:0]     bm_addr,
  output logic [9:0]      scr_addr,
  input  wire logic [7:0] bm_data,
  input  wire logic [7:0] scr_data,
  input  wire logic [3:0] col_data,
  output logic            color_valid,
  output logic            color_bitmap,
  output logic [3:0]      color_out
);

  bpg_state_type st_reg;
  bpg_state_type st_next;
  logic [7:0]    cur_bm;
  logic [7:0]    cur_scr;
  logic [3:0]    cur_col;
  logic [7:0]    shifted;

  // Mode from the two control bits
  function automatic bpg_mode_type mode_of(input logic [7:0] c1, input logic [7:0] c2);
    if (!c1[`BPG_CTRL1_BITMAP_BIT]) begin
      mode_of = bpg_mode_char;
    end else if (c2[`BPG_CTRL2_MULTI_BIT]) begin
      mode_of = bpg_mode_multi_color_bitmap;
    end else begin
      mode_of = bpg_mode_two_color_bitmap;
    end
  endfunction

  // Pair code to colour
  function automatic logic [3:0] pair_color(input logic [1:0] pair, input logic [3:0] bg,
                                            input logic [7:0] scr, input logic [3:0] col);
    case (pair)
      `BPG_PAIR_BG0:    pair_color = bg;
      `BPG_PAIR_SCR_HI: pair_color = scr[7:4];
      `BPG_PAIR_SCR_LO: pair_color = scr[3:0];
      default:          pair_color = col;
    endcase
  endfunction

  // Next state: address stage, then colour stage
  always_comb begin
    st_next = st_reg;
    st_next.s1_valid = pix_valid;
    st_next.fetch = 1'b0;
    if (pix_valid) begin
      st_next.s1_x_lo = pix_x[2:0];
      st_next.s1_mode = mode_of(ctrl1, ctrl2);
      st_next.s1_new_cell = (pix_x[2:0] == 3'h0);
      if (pix_x[2:0] == 3'h0) begin
        st_next.fetch = 1'b1;
        // Row*320 + cell*8 + line, origin top-left
        st_next.bm_addr = 13'(13'(pix_y[7:3]) * 13'(`BPG_ROW_BYTES))
                        + 13'({pix_x[8:3], 3'h0})
                        + 13'(pix_y[2:0]);
        st_next.scr_addr = 10'(10'(pix_y[7:3]) * 10'(`BPG_CELL_COLS)) + 10'(pix_x[8:3]);
      end else begin
        st_next.bm_addr = st_reg.bm_addr;
      end
    end
    // Data arrives in the same cycle as the registered address; later pixels use the held copy
    cur_bm  = st_reg.s1_new_cell ? bm_data  : st_reg.hold_bm;
    cur_scr = st_reg.s1_new_cell ? scr_data : st_reg.hold_scr;
    cur_col = st_reg.s1_new_cell ? col_data : st_reg.hold_col;
    shifted = 8'h00;
    st_next.out_valid = st_reg.s1_valid;
    if (st_reg.s1_valid) begin
      st_next.hold_bm  = cur_bm;
      st_next.hold_scr = cur_scr;
      st_next.hold_col = cur_col;
      case (st_reg.s1_mode)
        bpg_mode_two_color_bitmap: begin
          shifted = cur_bm << st_reg.s1_x_lo;
          st_next.out_bitmap = 1'b1;
          st_next.out_color = shifted[7] ? cur_scr[7:4] : cur_scr[3:0];
        end
        bpg_mode_multi_color_bitmap: begin
          shifted = cur_bm << {st_reg.s1_x_lo[2:1], 1'b0};
          st_next.out_bitmap = 1'b1;
          st_next.out_color = pair_color(shifted[7:6], bg0_color, cur_scr, cur_col);
        end
        default: begin
          st_next.out_bitmap = 1'b0;
          st_next.out_color = bg0_color;
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs straight from the state
  assign mem_fetch    = st_reg.fetch;
  assign bm_addr      = st_reg.bm_addr;
  assign scr_addr     = st_reg.scr_addr;
  assign color_valid  = st_reg.out_valid;
  assign color_bitmap = st_reg.out_bitmap;
  assign color_out    = st_reg.out_color;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  sequence cell_start_s;
    pix_valid && (pix_x[2:0] == 3'h0);
  endsequence

  chk_bitmap_addr_formula: assert property (cell_start_s |=>
    bm_addr == 13'($past(pix_y[7:3]) * 9'd320 + $past(pix_x[8:3]) * 4'd8 + $past(pix_y[2:0])))
    else $error("bitmap address wrong");
  chk_bitmap_addr_range: assert property (cell_start_s |=> bm_addr < 13'h1F40)
    else $error("bitmap address outside 8000 bytes");
  chk_screen_addr_formula: assert property (cell_start_s |=>
    scr_addr == 10'($past(pix_y[7:3]) * 6'd40 + $past(pix_x[8:3])))
    else $error("screen address wrong");
  chk_fetch_once_cell: assert property (pix_valid && (pix_x[2:0] != 3'h0) |=> !mem_fetch)
    else $error("fetch outside cell start");
  chk_latency_two: assert property (pix_valid |-> ##2 color_valid)
    else $error("pixel lost");
  chk_char_mode_flag: assert property (pix_valid && !ctrl1[5] |-> ##2 !color_bitmap)
    else $error("bitmap flag in character mode");
  chk_std_first_pixel: assert property (cell_start_s && ctrl1[5] && !ctrl2[4] |-> ##2
    color_out == ($past(bm_data[7]) ? $past(scr_data[7:4]) : $past(scr_data[3:0])))
    else $error("standard colour wrong");
  chk_std_last_pixel: assert property (pix_valid && pix_x[2:0] == 3'h7 && ctrl1[5] && !ctrl2[4] |-> ##2
    color_out == ($past(st_reg.hold_bm[0]) ? $past(st_reg.hold_scr[7:4]) : $past(st_reg.hold_scr[3:0])))
    else $error("rightmost bit wrong");
  chk_multi_colmem: assert property (cell_start_s && ctrl1[5] && ctrl2[4] ##1 bm_data[7:6] == 2'h3
    |=> color_out == $past(col_data))
    else $error("colour memory pair wrong");
  chk_multi_bg0: assert property (cell_start_s && ctrl1[5] && ctrl2[4] ##1 bm_data[7:6] == 2'h0
    |=> color_out == $past(bg0_color))
    else $error("background pair wrong");

endmodule

/* bench/bpg_mem_model.sv */
`timescale 1ns/10ps
module bpg_mem_model (
  input  wire logic        mem_fetch,
  input  wire logic [12:0] bm_addr,
  input  wire logic [9:0]  scr_addr,
  output logic [7:0]       bm_data,
  output logic [7:0]       scr_data,
  output logic [3:0]       col_data
);
  // Memory contents as fixed address patterns
  function automatic logic [7:0] bm_val(input logic [12:0] a);
    return a[7:0] ^ {3'h0, a[12:8]} ^ 8'hA6;
  endfunction
  function automatic logic [7:0] scr_val(input logic [9:0] a);
    return {a[3:0], a[7:4]} ^ {6'h00, a[9:8]} ^ 8'h5A;
  endfunction
  function automatic logic [3:0] col_val(input logic [9:0] a);
    return a[3:0] ^ a[7:4] ^ 4'h9;
  endfunction
  // Data valid only in the fetch answer cycle, inverted otherwise
  always_comb begin
    bm_data  = mem_fetch ? bm_val(bm_addr) : ~bm_val(bm_addr);
    scr_data = mem_fetch ? scr_val(scr_addr) : ~scr_val(scr_addr);
    col_data = mem_fetch ? col_val(scr_addr) : ~col_val(scr_addr);
  end
endmodule

/* bench/testbench.sv */
`timescale 1ns/10ps
module testbench;
  typedef struct {logic [7:0] c1, c2; logic [8:0] x; logic [7:0] y; logic [3:0] bg; int gap; logic bm;} bpgt_row_type;
  logic clk_sys, reset, pix_valid, mem_fetch, color_valid, color_bitmap, cur_bm, v1, v2, f1;
  logic [8:0] pix_x;
  logic [7:0] pix_y, ctrl1, ctrl2, bm_data, scr_data;
  logic [3:0] bg0_color, col_data, color_out;
  logic [12:0] bm_addr;
  logic [9:0] scr_addr;
  logic [4:0] e1, e2;
  logic [22:0] a1;
  int err_count = 0, n_tests = 0;
  bpgt_row_type rows [9] = '{'{8'h00, 8'h00, 9'h000, 8'h00, 4'h3, 0, 1'b0}, '{8'hDF, 8'hFF, 9'h008, 8'h05, 4'h7, 1, 1'b0},
    '{8'h20, 8'h00, 9'h000, 8'h00, 4'h1, 0, 1'b1}, '{8'h20, 8'hEF, 9'h138, 8'hC7, 4'h2, 0, 1'b1},
    '{8'h3B, 8'h00, 9'h0A0, 8'h64, 4'h4, 2, 1'b1}, '{8'h20, 8'h10, 9'h000, 8'h00, 4'h5, 0, 1'b1},
    '{8'hFF, 8'hFF, 9'h138, 8'hC7, 4'h6, 1, 1'b1}, '{8'h20, 8'h10, 9'h028, 8'h0D, 4'h8, 0, 1'b1},
    '{8'h20, 8'h10, 9'h0C8, 8'h40, 4'h0, 0, 1'b1}};
  bpg_pixel_gen u_dut (.clk_sys(clk_sys), .reset(reset), .pix_valid(pix_valid), .pix_x(pix_x), .pix_y(pix_y),
    .ctrl1(ctrl1), .ctrl2(ctrl2), .bg0_color(bg0_color), .mem_fetch(mem_fetch), .bm_addr(bm_addr),
    .scr_addr(scr_addr), .bm_data(bm_data), .scr_data(scr_data), .col_data(col_data), .color_valid(color_valid),
    .color_bitmap(color_bitmap), .color_out(color_out));
  bpg_mem_model u_mem (.mem_fetch(mem_fetch), .bm_addr(bm_addr), .scr_addr(scr_addr), .bm_data(bm_data),
    .scr_data(scr_data), .col_data(col_data));
  task automatic fail(input string m);
    $display("mismatch at %0t: %s", $time, m);
    err_count++;
  endtask
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Reference byte and cell addresses of a pixel
  function automatic logic [12:0] fba(input logic [8:0] x, input logic [7:0] y);
    return 13'(y[7:3]) * 13'h0140 + 13'(x[8:3]) * 13'h0008 + 13'(y[2:0]);
  endfunction
  function automatic logic [9:0] fsa(input logic [8:0] x, input logic [7:0] y);
    return 10'(y[7:3]) * 10'h028 + 10'(x[8:3]);
  endfunction
  // Reference pixel colour
  function automatic logic [3:0] ref_px(input logic [8:0] x, input logic [7:0] y);
    logic [7:0] b, s;
    logic [1:0] p;
    b = u_mem.bm_val(fba(x, y));
    s = u_mem.scr_val(fsa(x, y));
    p = {b[3'h7 - {x[2:1], 1'b0}], b[3'h6 - {x[2:1], 1'b0}]};
    if (!ctrl1[5]) return bg0_color;
    if (!ctrl2[4]) return b[3'h7 - x[2:0]] ? s[7:4] : s[3:0];
    case (p)
      2'h0: return bg0_color;
      2'h1: return s[7:4];
      2'h2: return s[3:0];
      default: return u_mem.col_val(fsa(x, y));
    endcase
  endfunction
  // Pipelined expectations compared at every edge out of reset
  always @(posedge clk_sys) begin
    if (reset) begin
      v1 <= 1'b0; v2 <= 1'b0; f1 <= 1'b0;
    end else begin
      n_tests++;
      if (color_valid !== v2) fail("colour valid timing");
      else if (v2 && {color_bitmap, color_out} !== e2) fail("pixel colour");
      if (mem_fetch !== f1 || (f1 && {bm_addr, scr_addr} !== a1)) fail("fetch address");
      v2 <= v1; e2 <= e1; v1 <= pix_valid; e1 <= {cur_bm, ref_px(pix_x, pix_y)};
      f1 <= pix_valid && pix_x[2:0] == 3'h0; a1 <= {fba(pix_x, pix_y), fsa(pix_x, pix_y)};
    end
  end
  // One cell line of eight pixels with optional gaps
  task automatic send_cell(input bpgt_row_type r, input int n);
    @(posedge clk_sys);
    ctrl1 <= r.c1; ctrl2 <= r.c2; bg0_color <= r.bg; cur_bm <= r.bm;
    for (int i = 0; i < n; i++) begin
      @(posedge clk_sys);
      pix_valid <= 1'b1; pix_x <= r.x + 9'(i); pix_y <= r.y;
      repeat (r.gap) @(posedge clk_sys) pix_valid <= 1'b0;
    end
    @(posedge clk_sys) pix_valid <= 1'b0;
    repeat (4) @(posedge clk_sys);
  endtask
  task automatic chk_zero;
    #1 if ({mem_fetch, color_valid, color_bitmap, color_out, bm_addr, scr_addr} !== '0) fail("outputs in reset");
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  initial begin
    {reset, pix_valid, pix_x, pix_y, ctrl1, ctrl2, bg0_color, cur_bm} = '0;
    reset = 1'b1;
    repeat (10) @(posedge clk_sys);
    chk_zero();
    reset <= 1'b0;
    foreach (rows[i]) send_cell(rows[i], 8);
    // Reset in mid cell line, then a cell at once after release
    fork send_cell(rows[6], 8); begin repeat (4) @(posedge clk_sys); reset <= 1'b1; end join_any
    disable fork;
    pix_valid <= 1'b0;
    @(posedge clk_sys);
    chk_zero();
    reset <= 1'b0;
    send_cell(rows[7], 8);
    conclude();
  end
  initial begin
    #20000;
    fail("timeout");
    conclude();
  end
endmodule
